// >>> bench/tmwk_core_model.sv
// Processor-side model: services both watchdogs over the kick lines.
// Assumes the bench raises active while software is healthy.
`timescale 1ns/1ns
module tmwk_core_model #(
  parameter int GAP = 10
) (
  input  wire logic        clk,
  input  wire logic        active,
  input  wire logic [63:0] timeout,
  output logic      [1:0]  kick,
  output logic      [63:0] wd_val
);
  int unsigned cnt = 0;
  initial kick = 2'h0;
  assign wd_val = timeout;
  // Kick well inside the timeout; a late kick would let expiry through
  always @(posedge clk) begin
    #1;
    cnt = (cnt + 1) % GAP;
    kick = (active && cnt == 0) ? 2'h3 : 2'h0;
  end
endmodule

// >>> bench/tmwk_top_tb.sv
// Self-checking bench for the timer group.
// Assumes the core model as watchdog service partner.
`timescale 1ns/1ns
module tmwk_top_tb;
  logic        clk = 1'b0, srst = 1'b1, tick_load = 1'b0, tick_en = 1'b0, tick_clr = 1'b0;
  logic        tick_pulse, tick_irq, sys_rst, wk_irq, wk_wake, slp_tick;
  logic        kick_on = 1'b0, slp_xo = 1'b0, wk_rc = 1'b0, wk_load = 1'b0;
  logic        wk_auto = 1'b0, wk_en = 1'b0, wk_clr = 1'b0;
  logic [31:0] tick_int = 32'h0, wk_val = 32'h0, tick_count, wk_count;
  logic [1:0]  dt_load = 2'h0, dt_en = 2'h0, dt_clr = 2'h0, dt_irq, wd_kick, wd_irq;
  logic [1:0]  wd_en = 2'h0, wd_rst_en = 2'h0, wd_clr = 2'h0, wd_rst_req;
  logic [63:0] dt_val = 64'h0, dt_count, wd_val, wd_timeout = 64'h0;
  logic [3:0]  dt_mode = 4'h0;
  int          num_errors = 0, checked = 0, cycles = 0;

  tmwk_top dut (.CLK(clk), .SRST(srst), .TICK_LOAD(tick_load), .TICK_INTERVAL(tick_int),
    .TICK_EN(tick_en), .TICK_IRQ_CLR(tick_clr), .TICK_PULSE(tick_pulse), .TICK_IRQ(tick_irq),
    .TICK_COUNT(tick_count), .DT_LOAD(dt_load), .DT_VAL(dt_val), .DT_MODE(dt_mode),
    .DT_EN(dt_en), .DT_IRQ_CLR(dt_clr), .DT_COUNT(dt_count), .DT_IRQ(dt_irq),
    .WD_KICK(wd_kick), .WD_VAL(wd_val), .WD_EN(wd_en), .WD_RST_EN(wd_rst_en),
    .WD_IRQ_CLR(wd_clr), .WD_IRQ(wd_irq), .WD_RST_REQ(wd_rst_req), .SYS_RST(sys_rst),
    .SLP_XO(slp_xo), .WK_SRC_RC(wk_rc), .WK_LOAD(wk_load), .WK_VAL(wk_val),
    .WK_AUTO(wk_auto), .WK_EN(wk_en), .WK_IRQ_CLR(wk_clr), .WK_IRQ(wk_irq),
    .WK_WAKE(wk_wake), .WK_COUNT(wk_count), .SLP_TICK(slp_tick));
  tmwk_core_model core (.clk(clk), .active(kick_on), .timeout(wd_timeout), .kick(wd_kick),
    .wd_val(wd_val));

  always #25 clk = ~clk;
  // Whole run is under 2000 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic t_tick();
    tick_int = 32'h3;
    tick_en = 1'b1;
    tick_load = 1'b1;
    step(1);
    tick_load = 1'b0;
    cmp("tick count", 32'h3, tick_count);
    step(3);
    cmp("tick pulse", 1'h1, tick_pulse);
    cmp("tick irq early", 1'h0, tick_irq);
    step(1);
    cmp("tick irq", 1'h1, tick_irq);
    cmp("tick reload", 32'h3, tick_count);
    tick_clr = 1'b1;
    step(1);
    tick_clr = 1'b0;
    cmp("tick irq clr", 1'h0, tick_irq);
    step(2);
    cmp("tick pulse 2", 1'h1, tick_pulse);
    tick_en = 1'b0;
  endtask

  // Mode code 3 is decoded as free-running, so it is run as well
  task automatic t_dual();
    logic [31:0] exp_after [4] = '{32'hFFFF_FFFF, 32'h2, 32'h0, 32'hFFFF_FFFF};
    dt_en = 2'h3;
    for (int i = 0; i < 2; i++) begin
      for (int m = 0; m < 4; m++) begin
        dt_val[32*i +: 32] = 32'h2;
        dt_mode[2*i +: 2] = 2'(m);
        dt_load = 2'h1 << i;
        dt_clr = 2'h1 << i;
        step(1);
        dt_load = 2'h0;
        dt_clr = 2'h0;
        cmp("dual count", 32'h2, dt_count[32*i +: 32]);
        step(2);
        cmp("dual zero", 32'h0, dt_count[32*i +: 32]);
        cmp("dual irq early", 1'h0, dt_irq[i]);
        step(1);
        cmp("dual irq", 1'h1, dt_irq[i]);
        cmp("dual next", exp_after[m], dt_count[32*i +: 32]);
      end
    end
    dt_en = 2'h0;
  endtask

  task automatic t_dog();
    wd_timeout = {32'h14, 32'h14};
    wd_en = 2'h3;
    wd_rst_en = 2'h1;
    kick_on = 1'b1;
    step(80);
    cmp("dog irq kept off", 2'h0, wd_irq);
    cmp("sys reset kept off", 1'h0, sys_rst);
    kick_on = 1'b0;
    for (int n = 0; n < 40 && wd_irq === 2'h0; n++)
      step(1);
    cmp("dog irq", 2'h3, wd_irq);
    cmp("dog reset request", 2'h3, wd_rst_req);
    cmp("sys reset early", 1'h0, sys_rst);
    step(1);
    cmp("sys reset", 1'h1, sys_rst);
    wd_clr = 2'h3;
    step(1);
    wd_clr = 2'h0;
    cmp("dog irq clr", 2'h0, wd_irq);
    step(1);
    cmp("sys reset off", 1'h0, sys_rst);
    wd_en = 2'h0;
  endtask

  task automatic xo_tick(input logic [31:0] exp, input logic exp_irq);
    int seen = 0;
    slp_xo = 1'b1;
    repeat (4) begin
      step(1);
      seen += (slp_tick === 1'b1);
    end
    slp_xo = 1'b0;
    step(2);
    cmp("sleep tick", 32'h1, seen);
    cmp("wake count", exp, wk_count);
    cmp("wake irq", exp_irq, wk_irq);
    cmp("wake line", exp_irq, wk_wake);
  endtask

  task automatic t_wake();
    wk_en = 1'b1;
    wk_val = 32'h2;
    wk_load = 1'b1;
    step(1);
    wk_load = 1'b0;
    cmp("wake load", 32'h2, wk_count);
    xo_tick(32'h1, 1'h0);
    xo_tick(32'h0, 1'h1);
    wk_clr = 1'b1;
    step(1);
    wk_clr = 1'b0;
    xo_tick(32'h0, 1'h0);
    wk_auto = 1'b1;
    wk_load = 1'b1;
    step(1);
    wk_load = 1'b0;
    xo_tick(32'h1, 1'h0);
    xo_tick(32'h0, 1'h1);
    xo_tick(32'h2, 1'h1);
  endtask

  task automatic t_rc();
    int first = -1;
    int gap = 0;
    wk_rc = 1'b1;
    wk_val = 32'h5;
    wk_load = 1'b1;
    step(1);
    wk_load = 1'b0;
    for (int n = 0; n < 1400 && gap == 0; n++) begin
      step(1);
      if (slp_tick === 1'b1) begin
        if (first < 0)
          first = n;
        else
          gap = n - first;
      end
      if (first >= 0 && n == first + 320)
        cmp("slow count", 32'h4, wk_count);
    end
    cmp("rc tick period", 32'h280, gap);
  endtask

  initial begin
    step(6);
    cmp("reset outputs", 32'h0, {tick_irq, dt_irq, wd_irq, wk_irq, sys_rst});
    srst = 1'b0;
    t_tick();
    t_dual();
    t_dog();
    t_wake();
    t_rc();
    end_of_test();
  end
endmodule

// >>> hw/tmwk_cnt_if.sv
// Control and status bundle between the timer top and one down-counter.
// Assumes one control end and one counter end per instance.
`timescale 1ns/1ns
interface tmwk_cnt_if;
  logic                  en;
  logic                  tick;
  logic                  load;
  logic [31:0]           load_val;
  tmwk_pkg::tmwk_mode_t  mode;
  logic                  expire;
  logic [31:0]           count;

  modport ctl (output en, output tick, output load, output load_val, output mode,
               input expire, input count);
  modport cnt (input en, input tick, input load, input load_val, input mode,
               output expire, output count);
endinterface

// >>> hw/tmwk_consts.svh
// Constants of the timer group: widths, indices, reset values, clock rates.
// Assumes inclusion by bare name from each design file.
`ifndef TMWK_CONSTS_SVH
`define TMWK_CONSTS_SVH

`define TMWK_W        32
`define TMWK_ZERO     32'h0000_0000
`define TMWK_ONE      32'h0000_0001
`define TMWK_ALL1     32'hFFFF_FFFF
`define TMWK_RST_CNT  32'h0000_0000

`define TMWK_NCNT     6
`define TMWK_IX_TICK  0
`define TMWK_IX_DT    1
`define TMWK_IX_WD    3
`define TMWK_IX_WK    5

`define TMWK_CLK_HZ   20000000
`define TMWK_RC_HZ    2000000
`define TMWK_RC_DIV   (`TMWK_CLK_HZ / `TMWK_RC_HZ)
`define TMWK_SLP_DIV  64
`define TMWK_SLP_CYC  (`TMWK_RC_DIV * `TMWK_SLP_DIV)

`endif

// >>> hw/tmwk_dcnt.sv
// One 32-bit down-counter with free, periodic and one-shot modes.
// Assumes tick is a one-cycle enable and load a one-cycle pulse.
`timescale 1ns/1ns
`include "tmwk_consts.svh"
module tmwk_dcnt (
  input  wire logic clk,
  input  wire logic srst,
  tmwk_cnt_if.cnt   c
);
  logic [31:0] reload;
  logic        running;
  logic        step;

  assign step = c.en && c.tick && running && !c.load;

  always_ff @(posedge clk) begin
    if (srst) begin
      reload <= `TMWK_RST_CNT;
    end else if (c.load) begin
      reload <= c.load_val;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      c.count <= `TMWK_RST_CNT;
    end else if (c.load) begin
      c.count <= c.load_val;
    end else if (step) begin
      if (c.count != `TMWK_ZERO) begin
        c.count <= c.count - `TMWK_ONE;
      end else begin
        unique case (c.mode)
          tmwk_pkg::TMWK_PERIODIC: c.count <= reload;
          tmwk_pkg::TMWK_ONESHOT:  c.count <= c.count;
          default:                 c.count <= `TMWK_ALL1;
        endcase
      end
    end
  end

  // Halt after a one-shot expiry until the next load
  always_ff @(posedge clk) begin
    if (srst) begin
      running <= 1'b0;
    end else if (c.load) begin
      running <= 1'b1;
    end else if (step && c.count == `TMWK_ONE && c.mode == tmwk_pkg::TMWK_ONESHOT) begin
      running <= 1'b0;
    end
  end

  // Expiry pulse in the cycle the count lands on zero
  always_ff @(posedge clk) begin
    if (srst) begin
      c.expire <= 1'b0;
    end else begin
      c.expire <= step && c.count == `TMWK_ONE;
    end
  end

  chk_expire_at_zero: assert property (@(posedge clk) disable iff (srst)
    c.expire |-> c.count == `TMWK_ZERO)
    else $error("expiry without zero count");
  chk_count_steps: assert property (@(posedge clk) disable iff (srst)
    step && c.count > `TMWK_ONE |=> c.count == $past(c.count) - `TMWK_ONE)
    else $error("count did not step by one");
  chk_periodic_reload: assert property (@(posedge clk) disable iff (srst)
    step && c.count == `TMWK_ZERO && c.mode == tmwk_pkg::TMWK_PERIODIC
    |=> c.count == $past(reload))
    else $error("periodic reload missed");
endmodule

// >>> hw/tmwk_pkg.sv
// Types shared by the timer group modules.
// Assumes nothing of its surroundings.
package tmwk_pkg;
  typedef enum logic [1:0] {
    TMWK_FREE     = 2'h0,
    TMWK_PERIODIC = 2'h1,
    TMWK_ONESHOT  = 2'h2
  } tmwk_mode_t;
endpackage

// >>> hw/tmwk_top.sv
// Timer group: tick timer, dual down-counter, two watchdogs, wakeup timer.
// Assumes all inputs synchronous to CLK; control pulses last one cycle.
//
// What this block does
// - 32-bit tick timer pulses periodically at a programmed interval.
// - Two independent 32-bit down-counters, each raising an interrupt on expiry.
// - Each dual counter runs free-running, periodic reload, or one-shot.
// - Two watchdogs interrupt the processor when they expire unserviced.
// - Each watchdog interrupt is also exported as a reset request output.
// - Watchdog applies system reset when software fails to service it.
// - Wakeup timer is a 32-bit down-counter on the sleep clock.
// - Wakeup timer raises an interrupt and a chip wakeup.
// - One-time mode: flag on expiry, then halt until reprogrammed.
// - Auto-reload mode: flag on expiry, then count again from reload.
// - RC sleep clock is the 2MHz RC divided by 64.
// - Slow sleep rate drives the always-on timer; main clock the rest.
`timescale 1ns/1ns
`include "tmwk_consts.svh"
module tmwk_top (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        TICK_LOAD,
  input  wire logic [31:0] TICK_INTERVAL,
  input  wire logic        TICK_EN,
  input  wire logic        TICK_IRQ_CLR,
  output logic             TICK_PULSE,
  output logic             TICK_IRQ,
  output logic      [31:0] TICK_COUNT,
  input  wire logic [1:0]  DT_LOAD,
  input  wire logic [63:0] DT_VAL,
  input  wire logic [3:0]  DT_MODE,
  input  wire logic [1:0]  DT_EN,
  input  wire logic [1:0]  DT_IRQ_CLR,
  output logic      [63:0] DT_COUNT,
  output logic      [1:0]  DT_IRQ,
  input  wire logic [1:0]  WD_KICK,
  input  wire logic [63:0] WD_VAL,
  input  wire logic [1:0]  WD_EN,
  input  wire logic [1:0]  WD_RST_EN,
  input  wire logic [1:0]  WD_IRQ_CLR,
  output logic      [1:0]  WD_IRQ,
  output logic      [1:0]  WD_RST_REQ,
  output logic             SYS_RST,
  input  wire logic        SLP_XO,
  input  wire logic        WK_SRC_RC,
  input  wire logic        WK_LOAD,
  input  wire logic [31:0] WK_VAL,
  input  wire logic        WK_AUTO,
  input  wire logic        WK_EN,
  input  wire logic        WK_IRQ_CLR,
  output logic             WK_IRQ,
  output logic             WK_WAKE,
  output logic      [31:0] WK_COUNT,
  output logic             SLP_TICK
);
  localparam logic [3:0] RC_DIV_LAST  = 4'(`TMWK_RC_DIV - 1);
  localparam logic [5:0] SLP_DIV_LAST = 6'(`TMWK_SLP_DIV - 1);

  tmwk_cnt_if cif[`TMWK_NCNT] ();

  genvar g;
  generate
    for (g = 0; g < `TMWK_NCNT; g++) begin : gcnt
      tmwk_dcnt u_cnt (
        .clk  (CLK),
        .srst (SRST),
        .c    (cif[g].cnt)
      );
    end
  endgenerate

  // Sleep clock enables: RC path is 2 MHz enable then divide by 64
  logic [3:0] rc_div;
  logic [5:0] slp_div;
  logic       rc_2m;
  logic       rc_tick;
  logic       xo_prev;
  logic       xo_tick;
  logic       slp_tick;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rc_div <= 4'h0;
    end else if (rc_div == RC_DIV_LAST) begin
      rc_div <= 4'h0;
    end else begin
      rc_div <= rc_div + 4'h1;
    end
  end

  assign rc_2m = rc_div == RC_DIV_LAST;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      slp_div <= 6'h00;
    end else if (rc_2m) begin
      slp_div <= slp_div + 6'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rc_tick <= 1'b0;
    end else begin
      rc_tick <= rc_2m && slp_div == SLP_DIV_LAST;
    end
  end

  // Crystal sleep clock arrives as a level; its rising edge is the tick
  always_ff @(posedge CLK) begin
    if (SRST) begin
      xo_prev <= 1'b0;
    end else begin
      xo_prev <= SLP_XO;
    end
  end

  assign xo_tick  = SLP_XO && !xo_prev;
  assign slp_tick = WK_SRC_RC ? rc_tick : xo_tick;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SLP_TICK <= 1'b0;
    end else begin
      SLP_TICK <= slp_tick;
    end
  end

  // Tick timer on the main clock, always periodic
  assign cif[`TMWK_IX_TICK].en       = TICK_EN;
  assign cif[`TMWK_IX_TICK].tick     = 1'b1;
  assign cif[`TMWK_IX_TICK].load     = TICK_LOAD;
  assign cif[`TMWK_IX_TICK].load_val = TICK_INTERVAL;
  assign cif[`TMWK_IX_TICK].mode     = tmwk_pkg::TMWK_PERIODIC;
  assign TICK_PULSE = cif[`TMWK_IX_TICK].expire;
  assign TICK_COUNT = cif[`TMWK_IX_TICK].count;

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      TICK_IRQ <= 1'b0;
    end else begin
      TICK_IRQ <= (TICK_IRQ && !TICK_IRQ_CLR) || cif[`TMWK_IX_TICK].expire;
    end
  end

  // Dual timer and watchdogs
  logic [1:0] dt_exp;
  logic [1:0] wd_exp;

  generate
    for (g = 0; g < 2; g++) begin : gpair
      assign cif[`TMWK_IX_DT + g].en       = DT_EN[g];
      assign cif[`TMWK_IX_DT + g].tick     = 1'b1;
      assign cif[`TMWK_IX_DT + g].load     = DT_LOAD[g];
      assign cif[`TMWK_IX_DT + g].load_val = DT_VAL[32*g +: 32];
      assign cif[`TMWK_IX_DT + g].mode     =
        tmwk_pkg::tmwk_mode_t'(DT_MODE[2*g +: 2]);
      assign dt_exp[g]            = cif[`TMWK_IX_DT + g].expire;
      assign DT_COUNT[32*g +: 32] = cif[`TMWK_IX_DT + g].count;

      // Watchdog is a one-shot that each kick reloads
      assign cif[`TMWK_IX_WD + g].en       = WD_EN[g];
      assign cif[`TMWK_IX_WD + g].tick     = 1'b1;
      assign cif[`TMWK_IX_WD + g].load     = WD_KICK[g];
      assign cif[`TMWK_IX_WD + g].load_val = WD_VAL[32*g +: 32];
      assign cif[`TMWK_IX_WD + g].mode     = tmwk_pkg::TMWK_ONESHOT;
      assign wd_exp[g] = cif[`TMWK_IX_WD + g].expire;
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (SRST) begin
      DT_IRQ <= 2'h0;
    end else begin
      DT_IRQ <= (DT_IRQ & ~DT_IRQ_CLR) | dt_exp;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WD_IRQ <= 2'h0;
    end else begin
      WD_IRQ <= (WD_IRQ & ~WD_IRQ_CLR) | wd_exp;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WD_RST_REQ <= 2'h0;
    end else begin
      WD_RST_REQ <= (WD_IRQ & ~WD_IRQ_CLR) | wd_exp;
    end
  end

  // Held until software clears the watchdog flag
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SYS_RST <= 1'b0;
    end else begin
      SYS_RST <= |(WD_IRQ & WD_RST_EN);
    end
  end

  // Wakeup timer counts sleep ticks only
  assign cif[`TMWK_IX_WK].en       = WK_EN;
  assign cif[`TMWK_IX_WK].tick     = slp_tick;
  assign cif[`TMWK_IX_WK].load     = WK_LOAD;
  assign cif[`TMWK_IX_WK].load_val = WK_VAL;
  assign cif[`TMWK_IX_WK].mode     =
    WK_AUTO ? tmwk_pkg::TMWK_PERIODIC : tmwk_pkg::TMWK_ONESHOT;
  assign WK_COUNT = cif[`TMWK_IX_WK].count;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WK_IRQ <= 1'b0;
    end else begin
      WK_IRQ <= (WK_IRQ && !WK_IRQ_CLR) || cif[`TMWK_IX_WK].expire;
    end
  end

  // Wake request follows the interrupt so a sleeping chip sees the same event
  assign WK_WAKE = WK_IRQ;

  // Helper for checking sleep tick spacing
  logic [9:0] gap;
  logic       gap_ok;

  always_ff @(posedge CLK) begin
    if (SRST || rc_tick) begin
      gap <= 10'h000;
    end else if (gap != 10'h3FF) begin
      gap <= gap + 10'h001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      gap_ok <= 1'b0;
    end else if (rc_tick) begin
      gap_ok <= 1'b1;
    end
  end

  chk_rc_tick_spacing: assert property (@(posedge CLK) disable iff (SRST)
    rc_tick && gap_ok |-> gap == 10'(`TMWK_SLP_CYC - 1))
    else $error("RC sleep tick spacing wrong");
  chk_tick_irq_sticky: assert property (@(posedge CLK) disable iff (SRST)
    TICK_IRQ && !TICK_IRQ_CLR |=> TICK_IRQ)
    else $error("tick interrupt dropped");
  chk_dt_irq_set: assert property (@(posedge CLK) disable iff (SRST)
    DT_COUNT[31:0] == `TMWK_ZERO && $changed(DT_COUNT[31:0]) && !$past(DT_LOAD[0])
    |=> DT_IRQ[0])
    else $error("dual timer expiry lost");
  chk_wd_sys_reset: assert property (@(posedge CLK) disable iff (SRST)
    wd_exp[0] && WD_RST_EN[0] |=> ##1 SYS_RST)
    else $error("watchdog reset not applied");
  chk_wd_export: assert property (@(posedge CLK) disable iff (SRST)
    wd_exp[1] |=> WD_RST_REQ[1] && WD_IRQ[1])
    else $error("watchdog request not exported");
  chk_wk_oneshot_halt: assert property (@(posedge CLK) disable iff (SRST)
    cif[`TMWK_IX_WK].expire && !WK_AUTO && !WK_LOAD && !$past(WK_LOAD)
    ##1 !WK_LOAD [*8] |-> WK_COUNT == `TMWK_ZERO)
    else $error("one-time wakeup kept counting");
  chk_wk_wake: assert property (@(posedge CLK) disable iff (SRST)
    cif[`TMWK_IX_WK].expire |=> WK_WAKE && WK_IRQ)
    else $error("wakeup not raised");

  // Output invariants that software relies on, and the RC divider range
  chk_sys_rst_follow: assert property (@(posedge CLK) disable iff (SRST)
    |(WD_IRQ & WD_RST_EN) |=> SYS_RST)
    else $error("system reset not held");
  chk_wd_req_copy: assert property (@(posedge CLK) disable iff (SRST)
    WD_RST_REQ == WD_IRQ)
    else $error("reset request differs from interrupt");
  chk_wd_irq_set: assert property (@(posedge CLK) disable iff (SRST)
    wd_exp[0] |=> WD_IRQ[0])
    else $error("watchdog interrupt lost");
  chk_dt_irq_sticky: assert property (@(posedge CLK) disable iff (SRST)
    DT_IRQ[1] && !DT_IRQ_CLR[1] |=> DT_IRQ[1])
    else $error("dual timer interrupt dropped");
  chk_wk_irq_sticky: assert property (@(posedge CLK) disable iff (SRST)
    WK_IRQ && !WK_IRQ_CLR |=> WK_IRQ)
    else $error("wakeup interrupt dropped");
  chk_tick_pulse_zero: assert property (@(posedge CLK) disable iff (SRST)
    TICK_PULSE |-> TICK_COUNT == `TMWK_ZERO)
    else $error("tick pulse without zero count");
  chk_tick_irq_set: assert property (@(posedge CLK) disable iff (SRST)
    TICK_PULSE |=> TICK_IRQ)
    else $error("tick interrupt not raised");
  chk_slp_tick_single: assert property (@(posedge CLK) disable iff (SRST)
    SLP_TICK |=> !SLP_TICK)
    else $error("sleep tick longer than one cycle");
  chk_wk_hold_off: assert property (@(posedge CLK) disable iff (SRST)
    !WK_EN && !WK_LOAD |=> WK_COUNT == $past(WK_COUNT))
    else $error("wakeup counted while disabled");
  chk_dt_free_wrap: assert property (@(posedge CLK) disable iff (SRST)
    dt_exp[1] && DT_MODE[3:2] == 2'h0 && DT_EN[1] && !DT_LOAD[1]
    |=> DT_COUNT[63:32] == `TMWK_ALL1)
    else $error("free-running counter did not wrap");
  chk_rc_div_range: assert property (@(posedge CLK) disable iff (SRST)
    rc_div <= RC_DIV_LAST)
    else $error("RC divider out of range");
endmodule
